// ---- verilog/lhr_top.sv ----
// lhr_top.sv: heartbeat supervision, relay failsafe, indicator timing
// and configuration button qualification behind an apb register file.
// assumes link events are one-cycle pulses synchronous to mclk.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "lhr_map.svh"
module lhr_top
  import lhr_pkg::*;
#(
  parameter int NREL      = 4,
  parameter int NLED      = 6,
  parameter int MS_CYCLES = `LHR_MS_NS / `LHR_CLK_NS
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            arst_n,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // radio link events
  input  wire logic            link_tx_ok,
  input  wire logic            link_rx_valid,
  input  wire logic [NREL-1:0] link_rx_inputs,
  // status check exchange
  output logic                 chk_req,
  input  wire logic            chk_done,
  input  wire logic            chk_ok,
  input  wire logic [NREL-1:0] chk_remote_inputs,
  // relay drive
  output logic [NREL-1:0]      relay_out,
  // signal strength indicators
  input  wire logic            rssi_valid,
  input  wire logic [2:0]      rssi_level,
  output logic [NLED-1:0]      rssi_led,
  // configuration connection
  input  wire logic            test_btn_n,
  input  wire logic            cfg_done,
  output logic                 cfg_open,
  // interrupt
  output logic                 irq
);

  ////////////////////////////////////////////////////////////////////////
  // constants and state

  localparam int IW      = `LHR_IRQ_W;
  localparam int HB_DEF  = `LHR_HB_DEF_HOUR * `LHR_SEC_PER_HOUR;
  localparam int PER_DEF = `LHR_PERSIST_DEF_SEC * `LHR_SEC_MS;
  localparam int BTN_MS  = `LHR_BTN_HOLD_SEC * `LHR_SEC_MS;

  typedef struct packed {
    lhr_state_t      st;
    logic [15:0]     hb_sec;
    logic [7:0]      mult;
    logic [15:0]     persist;
    logic            rdef_en;
    logic            rdef_st;
    logic            rssi_en;
    logic [9:0]      ms_cnt;
    logic [15:0]     sec_cnt;
    logic [7:0]      periods;
    logic            lost;
    logic            dflt;
    logic            chk_req;
    logic [NREL-1:0] relay;
    logic [15:0]     led_cnt;
    logic [2:0]      led_lvl;
    logic [12:0]     btn_cnt;
    logic            cfg_open;
    logic [IW-1:0]   stat;
    logic [IW-1:0]   en;
  } lhr_top_t;

  localparam lhr_top_t RST_S = '{
    st:      LHR_ST_LINKED,
    hb_sec:  16'(HB_DEF),
    mult:    `LHR_MULT_RST,
    persist: 16'(PER_DEF),
    rssi_en: 1'b1,
    default: '0
  };

  lhr_top_t        s;
  lhr_top_t        next_s;
  logic            ms_tick;
  logic            sec_tick;
  logic            hb_due;
  logic            succ;
  logic            wr_stb;
  logic            hit;
  logic [31:0]     rd_word;
  logic [IW-1:0]   ev;
  logic [IW-1:0]   clr;
  logic [NREL-1:0] want;

  ////////////////////////////////////////////////////////////////////////
  // millisecond enable and bus front end

  lhr_tick #(
    .DIV (MS_CYCLES)
  ) u_tick (
    .mclk   (mclk),
    .arst_n (arst_n),
    .tick   (ms_tick)
  );

  lhr_apb u_apb (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rd_word (rd_word),
    .hit     (hit),
    .wr_stb  (wr_stb)
  );

  ////////////////////////////////////////////////////////////////////////
  // read decode, no read side effects so a retried read is harmless

  always_comb begin
    rd_word = '0;
    hit = 1'b1;
    case (paddr)
      `LHR_OFF_CTRL: begin
        rd_word[`LHR_CTRL_RDEF_EN] = s.rdef_en;
        rd_word[`LHR_CTRL_RDEF_ST] = s.rdef_st;
        rd_word[`LHR_CTRL_RSSI_EN] = s.rssi_en;
      end
      `LHR_OFF_HB:       rd_word[15:0] = s.hb_sec;
      `LHR_OFF_MULT:     rd_word[7:0] = s.mult;
      `LHR_OFF_PERSIST:  rd_word[15:0] = s.persist;
      `LHR_OFF_STATUS: begin
        rd_word[`LHR_STS_LOST] = s.lost;
        rd_word[`LHR_STS_DFLT] = s.dflt;
        rd_word[`LHR_STS_CFG]  = s.cfg_open;
        rd_word[`LHR_STS_CHK]  = s.chk_req;
        rd_word[`LHR_STS_PER_LSB +: 8] = s.periods;
      end
      `LHR_OFF_INT_STAT: rd_word[IW-1:0] = s.stat;
      `LHR_OFF_INT_CLR:  rd_word = '0; // write-only
      `LHR_OFF_INT_EN:   rd_word[IW-1:0] = s.en;
      default:           hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    next_s = s;
    ev = '0;
    clr = '0;
    // a completed good check is a successful exchange as well
    succ = link_tx_ok | link_rx_valid | (chk_done & chk_ok);
    sec_tick = ms_tick && (s.ms_cnt == 10'(`LHR_SEC_MS - 1));
    hb_due = sec_tick && ((s.sec_cnt + 16'h0001) >= s.hb_sec);

    // software writes
    if (wr_stb) begin
      case (paddr)
        `LHR_OFF_CTRL: begin
          next_s.rdef_en = pwdata[`LHR_CTRL_RDEF_EN];
          next_s.rdef_st = pwdata[`LHR_CTRL_RDEF_ST];
          next_s.rssi_en = pwdata[`LHR_CTRL_RSSI_EN];
        end
        `LHR_OFF_HB:      next_s.hb_sec = pwdata[15:0];
        `LHR_OFF_MULT:    next_s.mult = pwdata[7:0];
        `LHR_OFF_PERSIST: next_s.persist = pwdata[15:0];
        `LHR_OFF_INT_CLR: clr = pwdata[IW-1:0];
        `LHR_OFF_INT_EN:  next_s.en = pwdata[IW-1:0];
        default: ;
      endcase
    end

    // sub-second count, realigned on every good exchange
    if (ms_tick) begin
      next_s.ms_cnt = sec_tick ? '0 : s.ms_cnt + 10'h001;
    end

    // heartbeat timer and period count since the last success
    if (succ) begin
      next_s.ms_cnt = '0;
      next_s.sec_cnt = '0;
      next_s.periods = '0;
      next_s.lost = 1'b0;
      next_s.dflt = 1'b0;
    end else if (hb_due) begin
      next_s.sec_cnt = '0;
      // saturate so a long outage never wraps back under the multiple
      if (s.periods != 8'hFF) begin
        next_s.periods = s.periods + 8'h01;
      end
    end else if (sec_tick) begin
      next_s.sec_cnt = s.sec_cnt + 16'h0001;
    end

    // supervision sequence
    case (s.st)
      LHR_ST_LINKED: begin
        if (hb_due && !succ) begin
          next_s.st = LHR_ST_CHECK;
          next_s.chk_req = 1'b1;
          ev[`LHR_IRQ_CHK] = 1'b1;
        end
      end
      LHR_ST_CHECK: begin
        if (chk_done) begin
          next_s.chk_req = 1'b0;
          if (chk_ok) begin
            next_s.st = LHR_ST_LINKED;
          end else begin
            next_s.st = LHR_ST_RETRY;
            next_s.lost = 1'b1;
            ev[`LHR_IRQ_FAIL] = 1'b1;
          end
        end
      end
      LHR_ST_RETRY: begin
        // retry once a second until any exchange gets through
        if (succ) begin
          next_s.st = LHR_ST_LINKED;
        end else if (sec_tick) begin
          next_s.st = LHR_ST_CHECK;
          next_s.chk_req = 1'b1;
        end
      end
      default: begin
        next_s.st = LHR_ST_LINKED;
        next_s.chk_req = 1'b0;
      end
    endcase

    // failsafe default, only while enabled and the link is down
    if (!s.rdef_en) begin
      next_s.dflt = 1'b0;
    end else if (s.lost && !succ && (s.periods >= s.mult)) begin
      if (!s.dflt) ev[`LHR_IRQ_DFLT] = 1'b1;
      next_s.dflt = 1'b1;
    end

    // relay drive: default, fresh remote state, or hold
    want = ~chk_remote_inputs;
    if (next_s.dflt) begin
      next_s.relay = {NREL{next_s.rdef_st}};
    end else if (link_rx_valid) begin
      next_s.relay = ~link_rx_inputs;
    end else if (s.st == LHR_ST_CHECK && chk_done && chk_ok &&
                 s.relay != want) begin
      next_s.relay = want;
      ev[`LHR_IRQ_MIS] = 1'b1;
    end

    // indicator persistence in milliseconds
    if (rssi_valid && s.rssi_en) begin
      next_s.led_lvl = rssi_level;
      next_s.led_cnt = s.persist;
    end else if (ms_tick && s.led_cnt != '0) begin
      next_s.led_cnt = s.led_cnt - 16'h0001;
    end

    // button hold qualification, any release restarts the count
    if (test_btn_n) begin
      next_s.btn_cnt = '0;
    end else if (ms_tick && s.btn_cnt != 13'(BTN_MS)) begin
      next_s.btn_cnt = s.btn_cnt + 13'h0001;
    end
    if (!s.cfg_open && next_s.btn_cnt == 13'(BTN_MS) &&
        s.btn_cnt != 13'(BTN_MS)) begin
      next_s.cfg_open = 1'b1;
      ev[`LHR_IRQ_CFG] = 1'b1;
    end else if (cfg_done) begin
      next_s.cfg_open = 1'b0;
    end

    // sticky status: a new event beats a clear in the same cycle
    next_s.stat = (s.stat & ~clr) | ev;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) s <= RST_S;
    else s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // bar graph: led i lit while rssi_en is set, the level exceeds i and time remains
  genvar gi;
  generate
    for (gi = 0; gi < NLED; gi++) begin : g_led
      assign rssi_led[gi] = s.rssi_en && (s.led_cnt != '0) &&
                            (s.led_lvl > 3'(gi));
    end
  endgenerate

  assign chk_req   = s.chk_req;
  assign relay_out = s.relay;
  assign cfg_open  = s.cfg_open;
  assign irq       = |(s.stat & s.en);

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_rst_cfg;
    $rose(arst_n) |-> s.hb_sec == 16'(HB_DEF) && !s.rdef_en &&
      s.rssi_en && s.persist == 16'(PER_DEF);
  endproperty
  a_rst_cfg: assert property (p_rst_cfg)
    else $error("wrong configuration after reset");

  property p_hb_start;
    s.st == LHR_ST_LINKED && hb_due && !succ |=>
      chk_req && s.st == LHR_ST_CHECK;
  endproperty
  a_hb_start: assert property (p_hb_start)
    else $error("silent interval did not start a check");

  property p_restart;
    succ |=> s.sec_cnt == '0 && s.periods == '0 && s.ms_cnt == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("heartbeat timer not restarted");

  property p_count;
    hb_due && !succ && s.periods != 8'hFF |=>
      s.periods == $past(s.periods) + 8'h01;
  endproperty
  a_count: assert property (p_count)
    else $error("period count did not advance");

  property p_fail;
    s.st == LHR_ST_CHECK && chk_done && !chk_ok |=>
      s.lost && s.st == LHR_ST_RETRY && !chk_req;
  endproperty
  a_fail: assert property (p_fail)
    else $error("failed check not recorded");

  property p_retry;
    s.st == LHR_ST_RETRY && sec_tick && !succ |=> chk_req;
  endproperty
  a_retry: assert property (p_retry)
    else $error("no retry after a failed check");

  property p_hold;
    !next_s.dflt && !link_rx_valid && !chk_done |=>
      $stable(relay_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("relay changed without cause");

  property p_off;
    !s.rdef_en |=> !s.dflt;
  endproperty
  a_off: assert property (p_off)
    else $error("default taken while feature off");

  property p_dflt;
    s.lost && s.rdef_en && !succ && s.periods >= s.mult |=>
      s.dflt && relay_out == {NREL{s.rdef_st}};
  endproperty
  a_dflt: assert property (p_dflt)
    else $error("relay default not applied");

  property p_mis;
    s.st == LHR_ST_CHECK && chk_done && chk_ok && s.relay != want &&
      !next_s.dflt && !link_rx_valid |=>
      relay_out == ~$past(chk_remote_inputs) && s.stat[`LHR_IRQ_MIS];
  endproperty
  a_mis: assert property (p_mis)
    else $error("output mismatch not corrected");

  property p_cfg;
    $rose(cfg_open) |-> $past(s.btn_cnt) == 13'(BTN_MS - 1) &&
      $past(test_btn_n) == 1'b0;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config opened without full hold");

  property p_led;
    rssi_valid && s.rssi_en && rssi_level != 3'h0 &&
      s.persist != 16'h0000 |=> rssi_led[0];
  endproperty
  a_led: assert property (p_led)
    else $error("indicator not lit");

endmodule : lhr_top

// ---- verilog/lhr_map.svh ----
// lhr_map.svh: register offsets, field positions, reset values and timing
// for the link heartbeat relay failsafe; included by the lhr_top module only.
`ifndef LHR_MAP_SVH
`define LHR_MAP_SVH
// timing, each in its own unit
`define LHR_CLK_NS          10
`define LHR_MS_NS           1000000
`define LHR_SEC_MS          1000
`define LHR_SEC_PER_HOUR    3600
`define LHR_HB_DEF_HOUR     1
`define LHR_PERSIST_DEF_SEC 1
`define LHR_BTN_HOLD_SEC    5
// register byte offsets
`define LHR_OFF_CTRL        8'h00
`define LHR_OFF_HB          8'h04
`define LHR_OFF_MULT        8'h08
`define LHR_OFF_PERSIST     8'h0C
`define LHR_OFF_STATUS      8'h10
`define LHR_OFF_INT_STAT    8'h14
`define LHR_OFF_INT_CLR     8'h18
`define LHR_OFF_INT_EN      8'h1C
// control fields
`define LHR_CTRL_RDEF_EN    0
`define LHR_CTRL_RDEF_ST    1
`define LHR_CTRL_RSSI_EN    2
// status fields
`define LHR_STS_LOST        0
`define LHR_STS_DFLT        1
`define LHR_STS_CFG         2
`define LHR_STS_CHK         3
`define LHR_STS_PER_LSB     8
// reset values
`define LHR_MULT_RST        8'h01
// interrupt status bits
`define LHR_IRQ_CHK         0
`define LHR_IRQ_FAIL        1
`define LHR_IRQ_DFLT        2
`define LHR_IRQ_MIS         3
`define LHR_IRQ_CFG         4
`define LHR_IRQ_W           5
`endif

// ---- verilog/lhr_pkg.sv ----
// lhr_pkg.sv: shared types of the link heartbeat relay failsafe
// assumes nothing of its surroundings
package lhr_pkg;

  // supervision states, one-hot
  typedef enum logic [2:0] {
    LHR_ST_LINKED = 3'b001,
    LHR_ST_CHECK  = 3'b010,
    LHR_ST_RETRY  = 3'b100
  } lhr_state_t;

  // apb slave state
  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
  } lhr_apb_t;

endpackage : lhr_pkg

// ---- verilog/lhr_tick.sv ----
// lhr_tick.sv: free-running divider giving a one-cycle enable pulse
// assumes one clock domain and DIV of at least two
`timescale 1ns/1ps
module lhr_tick
  import lhr_pkg::*;
#(
  parameter int DIV = 100000
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // enable pulse
  output logic      tick
);
  localparam int W = $clog2(DIV);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } lhr_tick_t;
  lhr_tick_t s, next_s;

  // count down so the compare is against zero
  always_comb begin
    next_s = s;
    next_s.tick = (s.cnt == '0);
    next_s.cnt = (s.cnt == '0) ? W'(DIV - 1) : s.cnt - 1'b1;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) s <= '0;
    else s <= next_s;
  end

  assign tick = s.tick;
endmodule : lhr_tick

// ---- verilog/lhr_apb.sv ----
// lhr_apb.sv: apb slave front end, one wait-free access phase
// assumes the register file decodes the address and returns rd_word
`timescale 1ns/1ps
module lhr_apb
  import lhr_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // register file side
  input  wire logic [31:0] rd_word,
  input  wire logic        hit,
  output logic             wr_stb
);
  lhr_apb_t s, next_s;

  // read data and error caught in setup so prdata comes from a flop
  always_comb begin
    next_s = s;
    if (psel && !penable) begin
      next_s.rdata = pwrite ? '0 : rd_word;
      next_s.err = !hit;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) s <= '0;
    else s <= next_s;
  end

  // access phase always completes in its first cycle
  assign pready  = psel & penable;
  assign pslverr = pready & s.err;
  assign wr_stb  = pready & pwrite & hit;
  assign prdata  = s.rdata;
endmodule : lhr_apb

// ---- test/lhr_remote.sv ----
// lhr_remote.sv: model of the paired unit answering status checks
// assumes chk_req comes from the block under test on mclk
`timescale 1ns/1ps
module lhr_remote (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // check exchange
  input  wire logic       chk_req,
  output logic            chk_done,
  output logic            chk_ok,
  output logic [3:0]      chk_remote_inputs,
  // behaviour chosen by the bench
  input  wire logic       fail_mode,
  input  wire logic [7:0] delay,
  input  wire logic [3:0] inputs_n
);
  logic [7:0] cnt;
  logic       served;
  //////////////////////////////////////////////////////////////////////////
  // one answer per request after delay cycles; between answers the data
  // lines toggle so a stale value never passes for a fresh report
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt               <= 8'h00;
      served            <= 1'b0;
      chk_done          <= 1'b0;
      chk_ok            <= 1'b0;
      chk_remote_inputs <= 4'h0;
    end else begin
      chk_done          <= 1'b0;
      chk_ok            <= ~chk_ok;
      chk_remote_inputs <= ~chk_remote_inputs;
      if (!chk_req) begin
        cnt    <= 8'h00;
        served <= 1'b0;
      end else if (!served) begin
        if (cnt == delay) begin
          chk_done          <= 1'b1;
          chk_ok            <= ~fail_mode;
          chk_remote_inputs <= inputs_n;
          served            <= 1'b1;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end
endmodule : lhr_remote

// ---- test/testbench.sv ----
// testbench.sv: self-checking bench of the heartbeat relay failsafe
// assumes lhr_top with a 5-cycle millisecond, so one second is 5000 cycles
`timescale 1ns/1ps
module testbench;
  import lhr_pkg::*;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, delay;
  logic [31:0] pwdata, prdata;
  logic link_tx_ok, link_rx_valid, chk_req, chk_done, chk_ok, rssi_valid;
  logic test_btn_n, cfg_done, cfg_open, irq, fail_mode;
  logic [3:0] link_rx_inputs, chk_remote_inputs, relay_out, inputs_n;
  logic [2:0] rssi_level;
  logic [5:0] rssi_led;
  int failures, compares, n;
  //////////////////////////////////////////////////////////////////////////
  // design and the paired unit
  lhr_top #(.MS_CYCLES(5)) i_dut (.mclk(mclk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_tx_ok(link_tx_ok), .link_rx_valid(link_rx_valid),
    .link_rx_inputs(link_rx_inputs), .chk_req(chk_req),
    .chk_done(chk_done), .chk_ok(chk_ok),
    .chk_remote_inputs(chk_remote_inputs), .relay_out(relay_out),
    .rssi_valid(rssi_valid), .rssi_level(rssi_level), .rssi_led(rssi_led),
    .test_btn_n(test_btn_n), .cfg_done(cfg_done), .cfg_open(cfg_open),
    .irq(irq));
  lhr_remote i_remote (.mclk(mclk), .arst_n(arst_n), .chk_req(chk_req),
    .chk_done(chk_done), .chk_ok(chk_ok),
    .chk_remote_inputs(chk_remote_inputs), .fail_mode(fail_mode),
    .delay(delay), .inputs_n(inputs_n));
  //////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  always #5 mclk = ~mclk;
  // report, verdict and comparisons
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int lo, hi, v);
    compares++;
    if (v < lo || v > hi) begin
      failures++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask : chk_rng
  // one apb transfer; the request holds until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int k;
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      chk("apb wait", 1, 0);
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e, m);
    logic [31:0] r;
    logic x;
    apb(1'b0, a, 32'h0, r, x);
    chk(nm, e, r & m);
  endtask : rdc
  // bounded wait for a condition on the outputs
  function automatic logic cond(input int s, input logic [3:0] v);
    case (s)
      0: return chk_req === 1'b1;
      1: return relay_out === v;
      2: return cfg_open === 1'b1;
      default: return chk_req === 1'b0;
    endcase
  endfunction : cond
  task automatic wait_on(input int s, input logic [3:0] v, input int b,
                         output int c);
    c = 0;
    while (!cond(s, v)) begin
      @(posedge mclk);
      #1;
      c++;
      if (c > b) begin
        chk("wait bound", 1, 0);
        give_verdict();
      end
    end
  endtask : wait_on
  // one-cycle event pulse: 0 tx, 1 rx, 2 rssi, 3 cfg done
  task automatic pulse(input int s);
    @(posedge mclk);
    case (s)
      0: link_tx_ok <= 1'b1;
      1: link_rx_valid <= 1'b1;
      2: rssi_valid <= 1'b1;
      default: cfg_done <= 1'b1;
    endcase
    @(posedge mclk);
    link_tx_ok <= 1'b0; link_rx_valid <= 1'b0;
    rssi_valid <= 1'b0; cfg_done <= 1'b0;
    #1;
  endtask : pulse
  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rdc("ctrl", 8'h00, 32'h4, 32'hFFFFFFFF);
    rdc("hb", 8'h04, 32'hE10, 32'hFFFFFFFF);
    rdc("mult", 8'h08, 32'h1, 32'hFFFFFFFF);
    rdc("persist", 8'h0C, 32'h3E8, 32'hFFFFFFFF);
    rdc("status", 8'h10, 32'h0, 32'hFFFFFFFF);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped err", 1, e);
  endtask : t_reset
  task automatic t_heartbeat;
    wr(8'h04, 32'h1);
    wr(8'h1C, 32'h1F);
    pulse(0);
    repeat (3000) @(posedge mclk);
    #1;
    chk("early check", 0, chk_req);
    pulse(0);
    wait_on(0, 4'h0, 6000, n);
    chk_rng("heartbeat gap", 4990, 5010, n);
    wait_on(3, 4'h0, 100, n);
    chk("relay corrected", 4'h5, relay_out);
    rdc("int check", 8'h14, 32'h9, 32'hFFFFFFFF);
    chk("irq set", 1, irq);
    wr(8'h18, 32'h1F);
    #1;
    chk("irq clear", 0, irq);
  endtask : t_heartbeat
  task automatic t_fail;
    @(posedge mclk);
    fail_mode <= 1'b1; delay <= 8'h28;
    wait_on(0, 4'h0, 5100, n);
    wait_on(3, 4'h0, 100, n);
    rdc("lost", 8'h10, 32'h1, 32'h3);
    chk("relay held", 4'h5, relay_out);
    rdc("int fail", 8'h14, 32'h2, 32'h2);
    wait_on(0, 4'h0, 5100, n);
    chk_rng("retry gap", 4900, 5010, n);
    chk("relay still held", 4'h5, relay_out);
  endtask : t_fail
  task automatic t_default;
    // multiple first: periods already exceed the reset multiple of one
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h7);
    chk("before timeout", 4'h5, relay_out);
    wait_on(1, 4'hF, 6000, n);
    rdc("periods", 8'h10, 32'h303, 32'hFF03);
    fail_mode <= 1'b0; inputs_n <= 4'h3;
    pulse(0);
    rdc("resumed", 8'h10, 32'h0, 32'h3);
    link_rx_inputs <= 4'h3;
    pulse(1);
    chk("relay follows", 4'hC, relay_out);
  endtask : t_default
  task automatic t_rssi;
    wr(8'h0C, 32'h2);
    rssi_level <= 3'h3;
    pulse(2);
    chk("leds lit", 6'h07, rssi_led);
    repeat (25) @(posedge mclk);
    #1;
    chk("leds dark", 6'h00, rssi_led);
    wr(8'h00, 32'h0);
    pulse(2);
    chk("leds off", 6'h00, rssi_led);
  endtask : t_rssi
  task automatic t_button;
    @(posedge mclk);
    test_btn_n <= 1'b0;
    repeat (20000) @(posedge mclk);
    #1;
    chk("short hold", 0, cfg_open);
    @(posedge mclk);
    test_btn_n <= 1'b1;
    @(posedge mclk);
    test_btn_n <= 1'b0;
    wait_on(2, 4'h0, 26000, n);
    chk_rng("hold time", 24900, 25100, n);
    rdc("int cfg", 8'h14, 32'h10, 32'h10);
    pulse(3);
    chk("cfg closed", 0, cfg_open);
    @(posedge mclk);
    test_btn_n <= 1'b1;
  endtask : t_button
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    mclk = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; link_tx_ok = 0; link_rx_valid = 0;
    link_rx_inputs = 4'hF; rssi_valid = 0; rssi_level = 3'h0;
    test_btn_n = 1; cfg_done = 0; fail_mode = 0; delay = 8'h00;
    inputs_n = 4'hA; failures = 0; compares = 0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_heartbeat();
    t_fail();
    t_default();
    t_rssi();
    t_button();
    give_verdict();
  end
endmodule : testbench
